/* rtl/converter_mode_control_regs.v */
// Converter phase, mode and core voltage change control registers
`timescale 1ns/10ps
`include "converter_mode_control_regs.vh"
module converter_mode_control_regs #(
   parameter [13:0] STEP_CYCLES = `STEP_CYCLES
) (
   core_clk,
   rst,
   reg_addr,
   reg_wdata,
   reg_wr,
   reg_rd,
   reg_rdata,
   reg_rvalid,
   core_voltage_setting,
   core_slew_setting,
   core_strap_pin,
   undervoltage_lockout,
   warm_reset_pin_n,
   power_on_reset_output,
   backup_rail_low,
   system_buck_en,
   core_buck_en,
   memory_buck_en,
   system_phase,
   memory_phase,
   core_phase,
   low_ripple,
   system_forced_fixed_frequency,
   core_forced_fixed_frequency,
   memory_forced_fixed_frequency,
   core_from_pin,
   core_vcode,
   core_change_busy,
   system_discharge,
   core_discharge,
   memory_discharge
);
   input  wire       core_clk;
   input  wire       rst;
   input  wire [7:0] reg_addr;
   input  wire [7:0] reg_wdata;
   input  wire       reg_wr;
   input  wire       reg_rd;
   output reg  [7:0] reg_rdata;
   output reg        reg_rvalid;
   input  wire [4:0] core_voltage_setting;
   input  wire [2:0] core_slew_setting;
   input  wire       core_strap_pin;
   input  wire       undervoltage_lockout;
   input  wire       warm_reset_pin_n;
   input  wire       power_on_reset_output;
   input  wire       backup_rail_low;
   input  wire       system_buck_en;
   input  wire       core_buck_en;
   input  wire       memory_buck_en;
   output reg  [1:0] system_phase;
   output reg  [1:0] memory_phase;
   output reg  [1:0] core_phase;
   output reg        low_ripple;
   output reg        system_forced_fixed_frequency;
   output reg        core_forced_fixed_frequency;
   output reg        memory_forced_fixed_frequency;
   output reg        core_from_pin;
   output reg  [4:0] core_vcode;
   output reg        core_change_busy;
   output reg        system_discharge;
   output reg        core_discharge;
   output reg        memory_discharge;

   localparam ST_IDLE = 2'b01;
   localparam ST_RAMP = 2'b10;
   localparam [4:0] PIN_IDLE = `PIN_IDLE_LEVELS;

   // Pin inputs in order: strap, warm reset, lockout, power-on, backup
   wire [4:0] pin_raw;
   wire [4:0] pin_level;

   assign pin_raw = {backup_rail_low, power_on_reset_output,
                     undervoltage_lockout, warm_reset_pin_n, core_strap_pin};

   genvar gi;
   generate
      for (gi = 0; gi < 5; gi = gi + 1) begin : sync_loop
         pin_sync #(
            .INIT (PIN_IDLE[gi])
         ) u_sync (
            .core_clk  (core_clk),
            .rst       (rst),
            .pin_in    (pin_raw[gi]),
            .level_out (pin_level[gi])
         );
      end
   endgenerate

   wire strap_high;
   wire pin_sel_event;

   assign strap_high = pin_level[0];
   assign pin_sel_event = ~pin_level[1] | pin_level[2] | pin_level[3] |
                          pin_level[4];

   reg  [7:0]  mode_reg;
   reg  [7:0]  mode_next;
   reg         go_reg;
   reg         go_next;
   reg         pin_sel_reg;
   reg         pin_sel_next;
   reg  [2:0]  disch_reg;
   reg  [2:0]  disch_next;
   reg  [1:0]  state_reg;
   reg  [1:0]  state_next;
   reg  [4:0]  vcode_reg;
   reg  [4:0]  vcode_next;
   reg  [13:0] step_cnt_reg;
   reg  [13:0] step_cnt_next;

   wire        wr_mode;
   wire        wr_change;
   wire [4:0]  target_code;
   wire [4:0]  strap_code;
   wire [13:0] step_period;
   wire        at_target;

   assign wr_mode   = reg_wr && (reg_addr == `PHASE_MODE_OFFSET);
   assign wr_change = reg_wr && (reg_addr == `CHANGE_DISCH_OFFSET);

   // Strap level picks 1.2 V or 1.575 V
   assign strap_code = strap_high ? `VCODE_STRAP_HIGH : `VCODE_STRAP_LOW;

   assign target_code = pin_sel_reg ? strap_code : core_voltage_setting;

   // Step spacing halves per slew code
   assign step_period = STEP_CYCLES >> core_slew_setting;

   // Done on code match, not on regulation
   assign at_target = (vcode_reg == target_code);

   // Phase, mode and forced PWM register
   always @* begin
      mode_next = mode_reg;
      if (wr_mode) begin
         mode_next = reg_wdata;
      end
   end

   // Core change control, discharge and pin select
   always @* begin
      go_next      = go_reg;
      pin_sel_next = pin_sel_reg;
      disch_next   = disch_reg;
      // Self clear when the ramp is done
      if (go_reg && (state_reg == ST_RAMP) && at_target) begin
         go_next = 1'b0;
      end
      if (wr_change) begin
         // A written 1 starts a change; a set beats the self clear
         if (reg_wdata[`GO_BIT]) begin
            go_next = 1'b1;
         end
         pin_sel_next = reg_wdata[`PIN_SEL_BIT];
         disch_next   = reg_wdata[`SYS_DISCH_BIT:`MEM_DISCH_BIT];
      end
      if (pin_sel_event) begin
         pin_sel_next = `PIN_SEL_RESET;
      end
   end

   // Core voltage code sequencer
   always @* begin
      state_next    = state_reg;
      vcode_next    = vcode_reg;
      step_cnt_next = step_cnt_reg;
      case (state_reg)
         ST_IDLE: begin
            // Start-up code follows the strap while pin selected
            if (pin_sel_reg) begin
               vcode_next = strap_code;
            end
            step_cnt_next = step_period - 14'h0001;
            if (go_reg) begin
               state_next = ST_RAMP;
            end
         end
         ST_RAMP: begin
            if (at_target) begin
               state_next    = ST_IDLE;
               step_cnt_next = step_period - 14'h0001;
            end else if (core_slew_setting == `SLEW_IMMEDIATE) begin
               // Immediate slew jumps to the target
               vcode_next = target_code;
            end else if (step_cnt_reg == 14'h0000) begin
               // One code step per slew interval
               if (vcode_reg < target_code) begin
                  vcode_next = vcode_reg + 5'h01;
               end else begin
                  vcode_next = vcode_reg - 5'h01;
               end
               step_cnt_next = step_period - 14'h0001;
            end else begin
               step_cnt_next = step_cnt_reg - 14'h0001;
            end
         end
         default: begin
            state_next    = ST_IDLE;
            step_cnt_next = step_period - 14'h0001;
         end
      endcase
   end

   always @(posedge core_clk) begin
      if (rst) begin
         // System phase resets to half cycle
         mode_reg[`SYS_PHASE_HI:`SYS_PHASE_LO] <= `SYS_PHASE_RESET;
         // Memory phase resets to three quarters
         mode_reg[`MEM_PHASE_HI:`MEM_PHASE_LO] <= `MEM_PHASE_RESET;
         mode_reg[`LOW_RIPPLE_BIT]             <= `LOW_RIPPLE_RESET;
         mode_reg[`SYS_FORCED_FIXED_FREQUENCY_BIT:`MEM_FORCED_FIXED_FREQUENCY_BIT] <= `FORCED_FIXED_FREQUENCY_RESET;
         go_reg       <= `GO_RESET;
         pin_sel_reg  <= `PIN_SEL_RESET;
         disch_reg    <= `DISCH_RESET;
         state_reg    <= ST_IDLE;
         vcode_reg    <= `VCODE_RESET;
         step_cnt_reg <= 14'h0000;
      end else begin
         mode_reg     <= mode_next;
         go_reg       <= go_next;
         pin_sel_reg  <= pin_sel_next;
         disch_reg    <= disch_next;
         state_reg    <= state_next;
         vcode_reg    <= vcode_next;
         step_cnt_reg <= step_cnt_next;
      end
   end

   // Register readback; unmapped offsets and unused bits read zero
   always @(posedge core_clk) begin
      if (rst) begin
         reg_rdata  <= 8'h00;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         if (reg_rd) begin
            case (reg_addr)
               `PHASE_MODE_OFFSET: begin
                  reg_rdata <= mode_reg;
               end
               `CHANGE_DISCH_OFFSET: begin
                  reg_rdata <= {go_reg, pin_sel_reg, 3'h0, disch_reg};
               end
               default: begin
                  reg_rdata <= 8'h00;
               end
            endcase
         end
      end
   end

   // Converter controls, registered so they never glitch
   always @(posedge core_clk) begin
      if (rst) begin
         system_phase                  <= `SYS_PHASE_RESET;
         memory_phase                  <= `MEM_PHASE_RESET;
         core_phase                    <= `CORE_PHASE_FIXED;
         low_ripple                    <= `LOW_RIPPLE_RESET;
         system_forced_fixed_frequency <= 1'b0;
         core_forced_fixed_frequency   <= 1'b0;
         memory_forced_fixed_frequency <= 1'b0;
         core_from_pin                 <= `PIN_SEL_RESET;
         core_vcode                    <= `VCODE_RESET;
         core_change_busy              <= 1'b0;
         system_discharge              <= 1'b0;
         core_discharge                <= 1'b0;
         memory_discharge              <= 1'b0;
      end else begin
         system_phase <= mode_reg[`SYS_PHASE_HI:`SYS_PHASE_LO];
         memory_phase <= mode_reg[`MEM_PHASE_HI:`MEM_PHASE_LO];
         core_phase   <= `CORE_PHASE_FIXED;
         low_ripple   <= mode_reg[`LOW_RIPPLE_BIT];
         system_forced_fixed_frequency <= mode_reg[`SYS_FORCED_FIXED_FREQUENCY_BIT];
         core_forced_fixed_frequency   <= mode_reg[`CORE_FORCED_FIXED_FREQUENCY_BIT];
         memory_forced_fixed_frequency <= mode_reg[`MEM_FORCED_FIXED_FREQUENCY_BIT];
         // Voltage source select to the analog side
         core_from_pin    <= pin_sel_reg;
         // Code drives the 25 mV step DAC
         core_vcode       <= vcode_reg;
         core_change_busy <= go_reg;
         // Discharge only while the converter is off
         system_discharge <= disch_reg[2] & ~system_buck_en;
         core_discharge   <= disch_reg[1] & ~core_buck_en;
         memory_discharge <= disch_reg[0] & ~memory_buck_en;
      end
   end
endmodule

/* rtl/converter_mode_control_regs.vh */
// Offsets, field positions, reset values and timing for the converter control
`ifndef CONVERTER_MODE_CONTROL_REGS_VH
`define CONVERTER_MODE_CONTROL_REGS_VH

// Register offsets on the internal register port
`define PHASE_MODE_OFFSET      8'h04
`define CHANGE_DISCH_OFFSET    8'h05

// Converter phase and mode register fields
`define SYS_PHASE_HI           7
`define SYS_PHASE_LO           6
`define MEM_PHASE_HI           5
`define MEM_PHASE_LO           4
`define LOW_RIPPLE_BIT         3
`define SYS_FORCED_FIXED_FREQUENCY_BIT           2
`define CORE_FORCED_FIXED_FREQUENCY_BIT          1
`define MEM_FORCED_FIXED_FREQUENCY_BIT           0
`define SYS_PHASE_RESET        2'h2
`define MEM_PHASE_RESET        2'h3
`define CORE_PHASE_FIXED       2'h0
`define LOW_RIPPLE_RESET       1'h0
`define FORCED_FIXED_FREQUENCY_RESET             3'h0

// Core change and discharge register fields
`define GO_BIT                 7
`define PIN_SEL_BIT            6
`define SYS_DISCH_BIT          2
`define CORE_DISCH_BIT         1
`define MEM_DISCH_BIT          0
`define GO_RESET               1'h0
`define PIN_SEL_RESET          1'h1
`define DISCH_RESET            3'h0

// Core voltage codes, 0.8 V plus 25 mV per step
`define VCODE_MIN              5'h00
`define VCODE_MAX              5'h1f
`define VCODE_STRAP_LOW        5'h10
`define VCODE_STRAP_HIGH       5'h1f
`define VCODE_RESET            5'h10

// Slew codes, slowest rate doubling per code
`define SLEW_IMMEDIATE         3'h7

// One 25 mV step at 0.225 mV/us, in ns, and the clock period in ns
`define STEP_TIME_NS           111111
`define CLK_PERIOD_NS          10
`define STEP_CYCLES            14'd11111

// Inactive levels of the pin inputs while the synchronisers fill
`define PIN_IDLE_LEVELS        5'h02

`endif

/* rtl/pin_sync.v */
// Three-flop pin synchroniser with agreement filter
`timescale 1ns/10ps
module pin_sync #(
   parameter INIT = 1'b0
) (
   core_clk,
   rst,
   pin_in,
   level_out
);
   input  wire core_clk;
   input  wire rst;
   input  wire pin_in;
   output reg  level_out;

   reg first_reg;
   reg second_reg;
   reg third_reg;

   // First flop only feeds the second, guarding against metastability
   always @(posedge core_clk) begin
      if (rst) begin
         first_reg  <= INIT;
         second_reg <= INIT;
         third_reg  <= INIT;
         level_out  <= INIT;
      end else begin
         first_reg  <= pin_in;
         second_reg <= first_reg;
         third_reg  <= second_reg;
         if (second_reg == third_reg) begin
            level_out <= third_reg;
         end
      end
   end
endmodule

/* sim/converter_mode_control_regs_bench.sv */
// Self-checking bench for the converter control registers
`timescale 1ns/10ps
module converter_mode_control_regs_bench;
   logic       core_clk = 1'b0;
   logic       rst = 1'b1;
   logic [4:0] core_voltage_setting = 5'h10;
   logic [2:0] core_slew_setting = 3'h0;
   logic       core_strap_pin = 1'b0;
   logic [3:0] ev = 4'h0;
   logic [2:0] en = 3'h7;
   int         err_count = 0;
   int         checks_done = 0;
   wire  [7:0] reg_addr, reg_wdata, reg_rdata;
   wire        reg_wr, reg_rd, reg_rvalid, low_ripple, core_from_pin;
   wire  [1:0] system_phase, memory_phase, core_phase;
   wire  [4:0] core_vcode;
   wire        core_change_busy, system_forced_fixed_frequency;
   wire        core_forced_fixed_frequency, memory_forced_fixed_frequency;
   wire        system_discharge, core_discharge, memory_discharge;
   wire        undervoltage_lockout = ev[0];
   wire        warm_reset_pin_n = !ev[1];
   wire        power_on_reset_output = ev[2];
   wire        backup_rail_low = ev[3];
   wire        system_buck_en = en[2];
   wire        core_buck_en = en[1];
   wire        memory_buck_en = en[0];
   wire  [3:0] mode_o = {low_ripple, system_forced_fixed_frequency,
      core_forced_fixed_frequency, memory_forced_fixed_frequency};
   wire  [2:0] dis_o = {system_discharge, core_discharge, memory_discharge};
   wire  [3:0] ph_o = {system_phase, memory_phase};

   // Short step period keeps ramps to tens of cycles
   converter_mode_control_regs #(.STEP_CYCLES(14'd16))
      i_converter_mode_control_regs (.core_clk, .rst, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid,
      .core_voltage_setting, .core_slew_setting, .core_strap_pin,
      .undervoltage_lockout, .warm_reset_pin_n, .power_on_reset_output,
      .backup_rail_low, .system_buck_en, .core_buck_en, .memory_buck_en,
      .system_phase, .memory_phase, .core_phase, .low_ripple,
      .system_forced_fixed_frequency, .core_forced_fixed_frequency,
      .memory_forced_fixed_frequency, .core_from_pin, .core_vcode,
      .core_change_busy, .system_discharge, .core_discharge,
      .memory_discharge);
   host_model i_host_model (.core_clk, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .reg_rvalid);
   always #5 core_clk = ~core_clk;

   task automatic check(input string nm, input logic [7:0] seen,
                        input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
         err_count++;
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      logic       v;
      i_host_model.rd(a, d, v);
      check("rvalid", {7'h0, v}, 8'h01);
      check("rdata", d, e);
   endtask
   task results;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task t_reset;
      rdchk(8'h04, 8'hb0);
      rdchk(8'h05, 8'h40);
      rdchk(8'h03, 8'h00);
      check("vcode", {3'h0, core_vcode}, 8'h10);
      check("core phase", {6'h0, core_phase}, 8'h00);
      check("busy idle", {7'h0, core_change_busy}, 8'h00);
      $display("test reset done");
   endtask
   task t_fields;
      for (int i = 0; i < 4; i++) begin
         i_host_model.wr(8'h04, 8'h55 * i);
         rdchk(8'h04, 8'h55 * i);
         // Phase codes fill the high nibble only
         check("phases", {ph_o, 4'h0}, 8'h50 * i);
         check("mode", {4'h0, mode_o}, 8'h05 * i);
      end
      // Bits 5..3 are not stored
      i_host_model.wr(8'h05, 8'h3f);
      rdchk(8'h05, 8'h07);
      check("from pin", {7'h0, core_from_pin}, 8'h00);
      check("disch on", {5'h0, dis_o}, 8'h00);
      en = 3'h5;
      cyc(2);
      check("disch off", {5'h0, dis_o}, 8'h02);
      en = 3'h0;
      cyc(2);
      check("disch all", {5'h0, dis_o}, 8'h07);
      en = 3'h7;
      i_host_model.wr(8'h05, 8'h00);
      $display("test fields done");
   endtask
   task t_ramp;
      logic [2:0] s [3];
      logic [4:0] t [3];
      logic [4:0] prev;
      int         n;
      int         p;
      int         k;
      s = '{3'h0, 3'h3, 3'h7};
      t = '{5'h14, 5'h11, 5'h1f};
      prev = 5'h10;
      for (int i = 0; i < 3; i++) begin
         core_slew_setting = s[i];
         core_voltage_setting = t[i];
         p = (s[i] == 3'h7) ? 0 : 16 >> s[i];
         k = (t[i] > prev) ? t[i] - prev : prev - t[i];
         i_host_model.wr(8'h05, 8'h80);
         // Busy lags the written bit by one cycle
         cyc(1);
         check("busy", {7'h0, core_change_busy}, 8'h01);
         n = 0;
         while (core_change_busy !== 1'b0 && n < 300) begin
            cyc(1);
            n++;
         end
         check("ramp min", {7'h0, n >= k * p}, 8'h01);
         check("ramp max", {7'h0, n <= k * p + 4}, 8'h01);
         check("target", {3'h0, core_vcode}, {3'h0, t[i]});
         rdchk(8'h05, 8'h00);
         prev = t[i];
      end
      $display("test ramp done");
   endtask
   task t_pin;
      i_host_model.wr(8'h05, 8'h40);
      cyc(8);
      check("strap low", {3'h0, core_vcode}, 8'h10);
      core_strap_pin = 1'b1;
      cyc(10);
      check("strap high", {3'h0, core_vcode}, 8'h1f);
      core_strap_pin = 1'b0;
      cyc(10);
      for (int i = 0; i < 4; i++) begin
         i_host_model.wr(8'h05, 8'h00);
         // Pin select output lags the bit by one cycle
         cyc(1);
         check("released", {7'h0, core_from_pin}, 8'h00);
         ev = 4'h1 << i;
         cyc(10);
         // A write of zero must lose to the event
         i_host_model.wr(8'h05, 8'h00);
         rdchk(8'h05, 8'h40);
         check("held", {7'h0, core_from_pin}, 8'h01);
         ev = 4'h0;
         cyc(10);
      end
      $display("test pin done");
   endtask

   initial begin
      cyc(12);
      rst = 1'b0;
      t_reset;
      t_fields;
      t_ramp;
      t_pin;
      rst = 1'b1;
      cyc(12);
      rst = 1'b0;
      t_reset;
      results;
   end
   initial begin
      #100000;
      err_count++;
      results;
   end
endmodule

/* sim/converter_mode_control_regs_properties.sv */
// Concurrent checks on the converter control register ports
`timescale 1ns/10ps
module mode_regs_properties (
   input logic       core_clk,
   input logic       rst,
   input logic [7:0] reg_addr,
   input logic [7:0] reg_wdata,
   input logic       reg_wr,
   input logic [4:0] core_voltage_setting,
   input logic [2:0] core_slew_setting,
   input logic       undervoltage_lockout,
   input logic       warm_reset_pin_n,
   input logic       power_on_reset_output,
   input logic       backup_rail_low,
   input logic [1:0] system_phase,
   input logic [1:0] core_phase,
   input logic       core_from_pin,
   input logic [4:0] core_vcode,
   input logic       core_change_busy
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);
   wire       wr4 = reg_wr && reg_addr == 8'h04;
   wire       go_wr = reg_wr && reg_addr == 8'h05 && reg_wdata[7]
                      && !reg_wdata[6];
   wire       sup = undervoltage_lockout || !warm_reset_pin_n
                    || power_on_reset_output || backup_rail_low;
   wire [1:0] wsys = reg_wdata[7:6];
   wire       at_tgt = core_vcode == core_voltage_setting && !core_from_pin;

   sys_phase_wr_a: assert property (
      wr4 |=> ##1 system_phase == $past(wsys, 2))
      else $error("system phase not applied");
   core_phase_fixed_a: assert property (
      core_phase == 2'h0) else $error("core phase not zero");
   go_sets_busy_a: assert property (
      go_wr |-> ##2 core_change_busy) else $error("change not started");
   single_step_a: assert property (
      $changed(core_vcode) && core_change_busy && core_slew_setting != 3'h7
      |-> core_vcode == $past(core_vcode) + 5'h01
       || core_vcode == $past(core_vcode) - 5'h01)
      else $error("core code jumped");
   self_clear_a: assert property (
      core_change_busy && at_tgt |-> ##[1:3] !core_change_busy)
      else $error("change bit not cleared");
   done_at_target_a: assert property (
      $fell(core_change_busy) && !core_from_pin
      |-> core_vcode == core_voltage_setting)
      else $error("change ended off target");
   immediate_slew_a: assert property (
      go_wr && core_slew_setting == 3'h7 && !core_from_pin
      |-> ##[1:4] core_vcode == core_voltage_setting)
      else $error("immediate slew too slow");
   event_pin_sel_a: assert property (
      sup [*8] |-> core_from_pin) else $error("pin select not restored");
   cover property (go_wr ##[1:100] $fell(core_change_busy));
   cover property (sup [*8]);
   cover property (wr4);
endmodule
bind converter_mode_control_regs mode_regs_properties i_mode_regs_properties (
   .core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .core_voltage_setting,
   .core_slew_setting, .undervoltage_lockout, .warm_reset_pin_n,
   .power_on_reset_output, .backup_rail_low, .system_phase, .core_phase,
   .core_from_pin, .core_vcode, .core_change_busy);

/* sim/host_model.sv */
// Host side model driving the register byte port
`timescale 1ns/10ps
module host_model (
   input  logic       core_clk,
   output logic [7:0] reg_addr = 8'h00,
   output logic [7:0] reg_wdata = 8'h00,
   output logic       reg_wr = 1'b0,
   output logic       reg_rd = 1'b0,
   input  logic [7:0] reg_rdata,
   input  logic       reg_rvalid
);
   // Data inverted after release so stale bytes never look valid
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk) #1;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge core_clk) #1;
      reg_wr = 1'b0;
      reg_wdata = ~d;
   endtask
   task rd(input logic [7:0] a, output logic [7:0] d, output logic v);
      @(posedge core_clk) #1;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge core_clk) #1;
      reg_rd = 1'b0;
      d = reg_rdata;
      v = reg_rvalid;
   endtask
endmodule
